// ---- pkg/nvm_pkg.sv ----
package nvm_pkg;
   // Register offsets on the special function register bus
   localparam logic [10:0] CTRL_OFFSET = 11'h760;
   localparam logic [10:0] ADDR_LOW_OFFSET = 11'h762;
   localparam logic [10:0] ADDR_UPPER_OFFSET = 11'h764;
   localparam logic [10:0] KEY_OFFSET = 11'h766;

   // Field positions inside nvm_control
   localparam int START_BIT = 15;
   localparam int WRITE_ENABLE_BIT = 14;
   localparam int WRITE_ERROR_BIT = 13;
   localparam int WRITE_INTERRUPT_SELECT_BIT = 8;
   localparam int OP_CODE_MSB = 6;
   localparam int OP_ERASE_BIT = 6;

   // Reset values
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] ADDR_RESET = 16'h0000;

   // Unlock key pair
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;

   // Target selection in the low nibble of program_operation_code
   localparam logic [3:0] TARGET_FLASH_ROW = 4'h1;
   localparam logic [3:0] TARGET_DATA_WORD = 4'h4;
   localparam logic [3:0] TARGET_DATA_BLOCK = 4'h5;

   // Data EEPROM window in program space (byte addresses, word step 2)
   localparam logic [23:0] EE_FIRST_ADDR = 24'h7FF000;
   localparam logic [23:0] EE_LAST_ADDR = 24'h7FFFFE;
   localparam int EE_DEPTH = 4096;
   localparam int EE_BLOCK_WORDS = 16;
   localparam logic [15:0] EE_ERASED_WORD = 16'hFFFF;
   localparam logic [15:0] EE_BUSY_READ_WORD = 16'hFFFF;

   // Operation time
   localparam int CLOCK_PERIOD_NS = 10;
   localparam int OP_TIME_MS = 2;
   localparam int OP_CYCLES = OP_TIME_MS * 1000000 / CLOCK_PERIOD_NS;

   // Core register access, one instruction's worth
   typedef struct packed {
      logic wr;
      logic rd;
      logic [10:0] addr;
      logic [15:0] wdata;
   } reg_req_t;

   // Table instruction access to program space
   typedef struct packed {
      logic rd_low;
      logic wr_low;
      logic [23:0] ea;
      logic [15:0] wdata;
   } table_req_t;
endpackage : nvm_pkg

// ---- core/nvm_op_timer.sv ----
`timescale 1ns/1ps
// Counts the length of one erase or program cycle
module nvm_op_timer #(
   parameter int unsigned CYCLES = 200000
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clock_enable,
   input wire logic start,
   input wire logic abort,
   output logic busy,
   output logic done
);
   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LOAD = W'(CYCLES);
   localparam logic [W-1:0] ONE = W'(1);

   logic [W-1:0] count;

   // Down counter; done pulses in the last counted cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
      end else if (clock_enable) begin
         if (abort) begin
            count <= '0;
         end else if (start) begin
            count <= LOAD;
         end else if (count != '0) begin
            count <= count - ONE;
         end
      end
   end

   assign busy = (count != '0);
   assign done = clock_enable && !abort && (count == ONE);

   a_timer_done_once: assert property (@(posedge clock) disable iff (!rst_n)
      done |=> !done) else $error("timer done lasted two cycles");
endmodule : nvm_op_timer

// ---- core/nvm_unlock_write_erase_ctrl.sv ----
`timescale 1ns/1ps
//
// Overview of operation
// - Erase or program starts only after key writes 0x55 then 0xAA.
// - Data EEPROM handles single words and sixteen-word blocks.
// - Target location is the low address joined with the upper address.
// - Data EEPROM, 2K words, sits at program words 0x7FF000 to 0x7FFFFE.
// - A data EEPROM cycle lasts typically two milliseconds.
// - Data EEPROM cycles never stall the processor.
// - Data reads during a cycle return unspecified data.
// - Software can set the start bit but never clear it.
// - Hardware clears the start bit when the cycle finishes.
// - Write enable gates starts and is clear after power-up.
// - Master-clear or watchdog reset during a cycle sets write error.
// - The low address register survives such a reset for a retry.
// - Memory-done flag sets at completion and holds until software clears.
// - Table read low returns the data EEPROM word at the address.
// - Block erase uses both address registers, erase code, enable, start.
// - Start needs write enable set by an earlier instruction.
// - Address registers capture the last table instruction's address.
// - Program flash cycles stall the processor until finished.
module nvm_unlock_write_erase_ctrl #(
   parameter int unsigned OP_CYCLES = nvm_pkg::OP_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clock_enable,
   input wire logic master_clear_reset,
   input wire logic watchdog_timer_reset,
   input wire logic instr_step,
   input wire nvm_pkg::reg_req_t reg_req,
   output logic [15:0] reg_rdata,
   input wire nvm_pkg::table_req_t table_req,
   output logic [15:0] table_rdata,
   input wire logic memory_done_clear,
   output logic memory_done_flag,
   output logic cpu_stall,
   output logic flash_op_start
);
   import nvm_pkg::*;

   typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} key_state_t;
   typedef enum logic [1:0] {ST_IDLE, ST_TIMING, ST_COMMIT} op_state_t;

   key_state_t key_state;
   op_state_t state;
   logic write_enable_bit;
   logic write_error_flag;
   logic write_interrupt_select;
   logic [OP_CODE_MSB:0] program_operation_code;
   logic [15:0] nvm_address_low;
   logic [7:0] nvm_address_upper;
   logic [3:0] commit_idx;
   logic [15:0] eeprom_mem [0:EE_DEPTH-1];
   logic [15:0] write_latch [0:EE_BLOCK_WORDS-1];

   logic warm_reset;
   logic ctrl_wr;
   logic key_wr;
   logic start_req;
   logic start_bit;
   logic timer_busy;
   logic timer_done;
   logic op_finish;
   logic is_erase;
   logic is_block;
   logic is_data;
   logic op_valid;
   logic [23:0] target;
   logic target_in_range;
   logic table_in_range;
   logic [11:0] table_index;
   logic [11:0] commit_index;
   logic [15:0] commit_word;

   ////////////////////////////////////////////////////////////////////////
   // Decode

   // Warm resets act only while the clock is enabled, like all other state
   assign warm_reset = clock_enable
                       && (master_clear_reset || watchdog_timer_reset);
   assign ctrl_wr = reg_req.wr && (reg_req.addr == CTRL_OFFSET);
   assign key_wr = reg_req.wr && (reg_req.addr == KEY_OFFSET);
   assign start_bit = (state != ST_IDLE);
   assign is_erase = program_operation_code[OP_ERASE_BIT];
   assign is_block = (program_operation_code[3:0] == TARGET_DATA_BLOCK);
   assign is_data = is_block
                    || (program_operation_code[3:0] == TARGET_DATA_WORD);
   assign op_valid = is_data
                     || (program_operation_code[3:0] == TARGET_FLASH_ROW);

   // Target joins both address registers
   assign target = {nvm_address_upper, nvm_address_low};
   assign target_in_range = (target >= EE_FIRST_ADDR)
                            && (target <= EE_LAST_ADDR);
   assign table_in_range = (table_req.ea >= EE_FIRST_ADDR)
                           && (table_req.ea <= EE_LAST_ADDR);
   assign table_index = table_req.ea[12:1];

   // Start needs the armed key and a write enable already stored; the
   // new value in the same write does not count
   assign start_req = clock_enable && !warm_reset && instr_step && ctrl_wr
                      && reg_req.wdata[START_BIT] && (key_state == KEY_ARMED)
                      && write_enable_bit && (state == ST_IDLE) && op_valid;

   ////////////////////////////////////////////////////////////////////////
   // Unlock key sequence

   // Keys count only on consecutive instructions; anything else disarms
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         key_state <= KEY_IDLE;
      end else if (warm_reset) begin
         key_state <= KEY_IDLE;
      end else if (clock_enable && instr_step) begin
         if (key_wr && reg_req.wdata[7:0] == KEY_FIRST) begin
            key_state <= KEY_HALF;
         end else if (key_wr && key_state == KEY_HALF
                      && reg_req.wdata[7:0] == KEY_SECOND) begin
            key_state <= KEY_ARMED;
         end else begin
            key_state <= KEY_IDLE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Operation sequencer

   nvm_op_timer #(
      .CYCLES(OP_CYCLES)
   ) u_timer (
      .clock(clock),
      .rst_n(rst_n),
      .clock_enable(clock_enable),
      .start(start_req),
      .abort(warm_reset),
      .busy(timer_busy),
      .done(timer_done)
   );

   // Data cycles commit their words after the timed cycle, one per clock
   assign op_finish = clock_enable && !warm_reset
                      && ((state == ST_TIMING && timer_done && !is_data)
                          || (state == ST_COMMIT
                              && (!is_block || commit_idx == 4'hF)));

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         commit_idx <= 4'h0;
      end else if (warm_reset) begin
         state <= ST_IDLE; // Start bit drops with the reset
         commit_idx <= 4'h0;
      end else if (clock_enable) begin
         unique case (state)
            ST_IDLE: begin
               commit_idx <= 4'h0;
               if (start_req) begin
                  state <= ST_TIMING;
               end
            end
            ST_TIMING: begin
               if (timer_done) begin
                  state <= is_data ? ST_COMMIT : ST_IDLE;
               end
            end
            ST_COMMIT: begin
               commit_idx <= commit_idx + 4'h1;
               if (op_finish) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Flash rows are programmed elsewhere; here only start and stall
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         flash_op_start <= 1'b0;
      end else if (clock_enable) begin
         flash_op_start <= start_req && !is_data;
      end
   end

   // Only program flash cycles hold the core
   assign cpu_stall = timer_busy && !is_data;

   ////////////////////////////////////////////////////////////////////////
   // Control register fields

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         write_enable_bit <= CTRL_RESET[WRITE_ENABLE_BIT];
         write_interrupt_select <= CTRL_RESET[WRITE_INTERRUPT_SELECT_BIT];
         program_operation_code <= CTRL_RESET[OP_CODE_MSB:0];
      end else if (warm_reset) begin
         write_enable_bit <= CTRL_RESET[WRITE_ENABLE_BIT];
         write_interrupt_select <= CTRL_RESET[WRITE_INTERRUPT_SELECT_BIT];
         program_operation_code <= CTRL_RESET[OP_CODE_MSB:0];
      end else if (clock_enable && ctrl_wr) begin
         // Clearing enable mid-cycle does not disturb the running cycle
         write_enable_bit <= reg_req.wdata[WRITE_ENABLE_BIT];
         write_interrupt_select <= reg_req.wdata[WRITE_INTERRUPT_SELECT_BIT];
         if (state == ST_IDLE) begin
            program_operation_code <= reg_req.wdata[OP_CODE_MSB:0];
         end
      end
   end

   // Interrupted cycle sets the error; this set wins over a clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         write_error_flag <= CTRL_RESET[WRITE_ERROR_BIT];
      end else if (warm_reset && start_bit) begin
         write_error_flag <= 1'b1;
      end else if (clock_enable && ctrl_wr) begin
         write_error_flag <= reg_req.wdata[WRITE_ERROR_BIT];
      end
   end

   // Completion flag; a finish in the clearing cycle keeps it set
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         memory_done_flag <= 1'b0;
      end else if (op_finish) begin
         memory_done_flag <= 1'b1;
      end else if (clock_enable && memory_done_clear) begin
         memory_done_flag <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Address registers

   // Warm resets leave the address untouched for a retry
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         nvm_address_low <= ADDR_RESET;
         nvm_address_upper <= ADDR_RESET[7:0];
      end else if (clock_enable && !warm_reset) begin
         if (table_req.rd_low || table_req.wr_low) begin
            nvm_address_low <= table_req.ea[15:0];
            nvm_address_upper <= table_req.ea[23:16];
         end else if (reg_req.wr && reg_req.addr == ADDR_LOW_OFFSET) begin
            nvm_address_low <= reg_req.wdata;
         end else if (reg_req.wr && reg_req.addr == ADDR_UPPER_OFFSET) begin
            nvm_address_upper <= reg_req.wdata[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data EEPROM array and write latches

   // Block commits walk the sixteen aligned words
   assign commit_index = is_block ? {target[12:5], commit_idx}
                                  : target[12:1];
   assign commit_word = is_erase ? EE_ERASED_WORD
                        : write_latch[is_block ? commit_idx : target[4:1]];

   // Array and latches carry no reset; their contents are data
   always_ff @(posedge clock) begin
      if (clock_enable && !warm_reset) begin
         if (table_req.wr_low && table_in_range) begin
            write_latch[table_req.ea[4:1]] <= table_req.wdata;
         end
         if (state == ST_COMMIT && target_in_range) begin
            eeprom_mem[commit_index] <= commit_word;
         end
      end
   end

   // Table read low; the array is not trusted while a data EEPROM cycle runs
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         table_rdata <= 16'h0000;
      end else if (clock_enable && table_req.rd_low) begin
         if (!table_in_range) begin
            table_rdata <= 16'h0000;
         end else if (start_bit && is_data) begin
            table_rdata <= EE_BUSY_READ_WORD;
         end else begin
            table_rdata <= eeprom_mem[table_index];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register reads

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else if (clock_enable && reg_req.rd) begin
         unique case (reg_req.addr)
            CTRL_OFFSET: reg_rdata <= {start_bit, write_enable_bit,
                                       write_error_flag, 4'h0,
                                       write_interrupt_select, 1'b0,
                                       program_operation_code};
            ADDR_LOW_OFFSET: reg_rdata <= nvm_address_low;
            ADDR_UPPER_OFFSET: reg_rdata <= {8'h00, nvm_address_upper};
            KEY_OFFSET: reg_rdata <= 16'h0000;
            default: reg_rdata <= 16'h0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   sequence s_key_pair;
      key_state == KEY_HALF ##1 key_state == KEY_ARMED
      ##[0:1] (key_state == KEY_ARMED && instr_step);
   endsequence

   a_start_needs_key: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(start_bit) |-> $past(key_state) == KEY_ARMED)
      else $error("start bit rose without the key pair");

   a_key_armed_once: assert property (@(posedge clock) disable iff (!rst_n)
      s_key_pair ##0 (clock_enable && !start_req)
      |=> key_state != KEY_ARMED && !$rose(start_bit))
      else $error("unlock outlived the next instruction");

   a_start_needs_write_enable_bit: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(start_bit) |-> $past(write_enable_bit))
      else $error("start bit rose without prior write enable");

   a_start_sticky: assert property (@(posedge clock) disable iff (!rst_n)
      start_bit && !op_finish && !warm_reset |=> start_bit)
      else $error("start bit cleared before completion");

   a_finish_flags: assert property (@(posedge clock) disable iff (!rst_n)
      op_finish |=> !start_bit && memory_done_flag)
      else $error("completion did not clear start and set done");

   a_done_sticky: assert property (@(posedge clock) disable iff (!rst_n)
      memory_done_flag && !memory_done_clear |=> memory_done_flag)
      else $error("done flag dropped without a clear");

   a_reset_error: assert property (@(posedge clock) disable iff (!rst_n)
      warm_reset && start_bit |=> write_error_flag && !start_bit)
      else $error("interrupted cycle did not set write error");

   a_address_kept: assert property (@(posedge clock) disable iff (!rst_n)
      warm_reset |=> $stable(nvm_address_low))
      else $error("warm reset changed the low address");

   a_data_no_stall: assert property (@(posedge clock) disable iff (!rst_n)
      start_bit && is_data |-> !cpu_stall)
      else $error("data EEPROM cycle stalled the core");

   a_flash_stall: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(start_bit) && !is_data |-> cpu_stall ##1 cpu_stall)
      else $error("flash cycle did not stall the core");

   a_key_reads_zero: assert property (@(posedge clock) disable iff (!rst_n)
      clock_enable && reg_req.rd && reg_req.addr == KEY_OFFSET
      |=> reg_rdata == 16'h0000)
      else $error("key register read back nonzero");
endmodule : nvm_unlock_write_erase_ctrl

// ---- testbench/cpu.sv ----
`timescale 1ns/1ps
// Processor core model: one register or table access per instruction
module cpu (
   input wire logic clock,
   input wire logic cpu_stall,
   input wire logic [15:0] reg_rdata,
   input wire logic [15:0] table_rdata,
   output nvm_pkg::reg_req_t reg_req,
   output nvm_pkg::table_req_t table_req,
   output logic instr_step
);
   import nvm_pkg::*;
   ////////////////////////////////////////////////////////////////////////////
   // Idle bus from time zero
   initial begin
      instr_step = 1'b0;
      reg_req = '0;
      table_req = '0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // One instruction; a stalled core issues nothing
   task automatic step(input reg_req_t r, input table_req_t t);
      for (int i = 0; i < 1000 && cpu_stall === 1'b1; i++) @(negedge clock);
      // A stall that never ends is a hang, not a slow cycle
      if (cpu_stall === 1'b1) begin
         tb.check(cpu_stall, 1'b0);
         tb.end_sim();
      end
      @(negedge clock);
      instr_step = 1'b1;
      reg_req = r;
      table_req = t;
      @(negedge clock);
      instr_step = 1'b0;
      // Released lines show the inverse so stale data cannot pass
      reg_req = '{1'b0, 1'b0, ~r.addr, ~r.wdata};
      table_req = '{1'b0, 1'b0, ~t.ea, ~t.wdata};
   endtask : step
   task automatic reg_wr(input logic [10:0] a, input logic [15:0] d);
      step('{1'b1, 1'b0, a, d}, '0);
   endtask : reg_wr
   task automatic reg_rd(input logic [10:0] a, output logic [15:0] d);
      step('{1'b0, 1'b1, a, 16'h0000}, '0);
      @(negedge clock);
      d = reg_rdata;
   endtask : reg_rd
   task automatic tbl_wr(input logic [23:0] ea, input logic [15:0] d);
      step('0, '{1'b0, 1'b1, ea, d});
   endtask : tbl_wr
   task automatic tbl_rd(input logic [23:0] ea, output logic [15:0] d);
      step('0, '{1'b1, 1'b0, ea, 16'h0000});
      @(negedge clock);
      d = table_rdata;
   endtask : tbl_rd
   // Enable, key pair, optional idle gap, start, two idle slots; no interrupt can cut
   task automatic run_op(input logic [15:0] first, input logic [15:0] start,
                         input bit gap);
      reg_wr(CTRL_OFFSET, first); // enable goes in ahead of start
      reg_wr(KEY_OFFSET, {8'h00, KEY_FIRST});
      reg_wr(KEY_OFFSET, {8'h00, KEY_SECOND});
      if (gap) step('0, '0);
      reg_wr(CTRL_OFFSET, start);
      step('0, '0);
      step('0, '0);
   endtask : run_op
endmodule : cpu

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
   import nvm_pkg::*;
   localparam int unsigned OPC = 40;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic clock_enable = 1'b1;
   logic master_clear_reset = 1'b0;
   logic watchdog_timer_reset = 1'b0;
   logic memory_done_clear = 1'b0;
   logic instr_step;
   reg_req_t reg_req;
   table_req_t table_req;
   logic [15:0] reg_rdata;
   logic [15:0] table_rdata;
   logic memory_done_flag;
   logic cpu_stall;
   logic flash_op_start;
   logic [15:0] v;
   int err_count = 0;
   int n_tests = 0;
   int pulses = 0;
   int stalls = 0;
   ////////////////////////////////////////////////////////////////////////////
   nvm_unlock_write_erase_ctrl #(.OP_CYCLES(OPC))
      nvm_unlock_write_erase_ctrl_inst (
      .clock(clock), .rst_n(rst_n), .clock_enable(clock_enable),
      .master_clear_reset(master_clear_reset),
      .watchdog_timer_reset(watchdog_timer_reset),
      .instr_step(instr_step), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .table_req(table_req), .table_rdata(table_rdata),
      .memory_done_clear(memory_done_clear),
      .memory_done_flag(memory_done_flag), .cpu_stall(cpu_stall),
      .flash_op_start(flash_op_start));
   cpu cpu_inst (.clock(clock), .cpu_stall(cpu_stall),
      .reg_rdata(reg_rdata), .table_rdata(table_rdata), .reg_req(reg_req),
      .table_req(table_req), .instr_step(instr_step));
   ////////////////////////////////////////////////////////////////////////////
   // Clock, and tallies of flash pulses and stalled cycles
   always #5 clock = ~clock;
   always @(negedge clock) begin
      if (flash_op_start === 1'b1) pulses <= pulses + 1;
      if (cpu_stall === 1'b1) stalls <= stalls + 1;
   end
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim();
      $display("checks=%0d errors=%0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   // Bounded wait for completion, then sticky flag and its clear
   task automatic wait_done();
      for (int i = 0; i < 400 && memory_done_flag !== 1'b1; i++)
         @(negedge clock);
      if (memory_done_flag !== 1'b1) begin
         check(memory_done_flag, 1'b1);
         end_sim();
      end
      repeat (3) @(negedge clock);
      check(memory_done_flag, 1'b1);
      cpu_inst.reg_rd(CTRL_OFFSET, v);
      check(v[15], 1'b0);
      memory_done_clear = 1'b1;
      @(negedge clock);
      memory_done_clear = 1'b0;
      check(memory_done_flag, 1'b0);
   endtask : wait_done
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      cpu_inst.reg_rd(CTRL_OFFSET, v);
      check(v, CTRL_RESET);
      cpu_inst.reg_wr(KEY_OFFSET, 16'h0055);
      cpu_inst.reg_rd(KEY_OFFSET, v);
      check(v, 16'h0000);
      cpu_inst.reg_rd(11'h770, v);
      check(v, 16'h0000);
   endtask : t_reset
   // Starts without keys, without earlier enable, with a stray instruction
   task automatic t_refused();
      cpu_inst.reg_wr(CTRL_OFFSET, 16'h4004);
      cpu_inst.reg_wr(CTRL_OFFSET, 16'hC004);
      cpu_inst.reg_rd(CTRL_OFFSET, v);
      check(v[15], 1'b0);
      cpu_inst.run_op(16'h0004, 16'hC004, 1'b0);
      cpu_inst.reg_rd(CTRL_OFFSET, v);
      check(v[15], 1'b0);
      cpu_inst.run_op(16'h4004, 16'hC004, 1'b1);
      cpu_inst.reg_rd(CTRL_OFFSET, v);
      check(v[15], 1'b0);
   endtask : t_refused
   // Word erase then program; erase first, as the cell needs
   task automatic t_word();
      int base;
      base = stalls;
      cpu_inst.tbl_wr(24'h7FF004, 16'h1234);
      cpu_inst.reg_rd(ADDR_LOW_OFFSET, v);
      check(v, 16'hF004);
      cpu_inst.reg_rd(ADDR_UPPER_OFFSET, v);
      check(v, 16'h007F);
      cpu_inst.run_op(16'h4044, 16'hC044, 1'b0);
      cpu_inst.reg_wr(CTRL_OFFSET, 16'h4044);
      cpu_inst.reg_rd(CTRL_OFFSET, v);
      check(v[15], 1'b1);
      cpu_inst.tbl_rd(24'h7FF004, v);
      check(v, EE_BUSY_READ_WORD);
      wait_done();
      cpu_inst.tbl_rd(24'h7FF004, v);
      check(v, EE_ERASED_WORD);
      cpu_inst.run_op(16'h4004, 16'hC004, 1'b0);
      wait_done();
      cpu_inst.tbl_rd(24'h7FF004, v);
      check(v, 16'h1234);
      check(stalls - base, 0);
   endtask : t_word
   task automatic t_block();
      cpu_inst.reg_wr(ADDR_UPPER_OFFSET, 16'h007F);
      cpu_inst.reg_wr(ADDR_LOW_OFFSET, 16'hF000);
      cpu_inst.run_op(16'h4045, 16'hC045, 1'b0);
      wait_done();
      cpu_inst.tbl_rd(24'h7FF004, v);
      check(v, EE_ERASED_WORD);
      cpu_inst.tbl_rd(24'h7FF01E, v);
      check(v, EE_ERASED_WORD);
      cpu_inst.tbl_rd(24'h7FEFFE, v);
      check(v, 16'h0000);
      cpu_inst.tbl_rd(24'h800000, v);
      check(v, 16'h0000);
   endtask : t_block
   task automatic t_flash();
      int p;
      int s;
      p = pulses;
      s = stalls;
      cpu_inst.run_op(16'h4001, 16'hC001, 1'b0);
      wait_done();
      check(pulses - p, 1);
      check(stalls - s, OPC);
   endtask : t_flash
   // Warm reset in mid-cycle; the op must never finish afterwards
   task automatic t_warm();
      for (int k = 0; k < 2; k++) begin
         cpu_inst.reg_wr(ADDR_LOW_OFFSET, 16'hF010);
         cpu_inst.run_op(16'h4044, 16'hC044, 1'b0);
         master_clear_reset = (k == 0);
         watchdog_timer_reset = (k == 1);
         @(negedge clock);
         master_clear_reset = 1'b0;
         watchdog_timer_reset = 1'b0;
         repeat (OPC + 20) @(negedge clock);
         cpu_inst.reg_rd(CTRL_OFFSET, v);
         check(v, 16'h2000);
         cpu_inst.reg_rd(ADDR_LOW_OFFSET, v);
         check(v, 16'hF010);
         check(memory_done_flag, 1'b0);
         cpu_inst.reg_wr(CTRL_OFFSET, 16'h0000);
      end
   endtask : t_warm
   // Frozen clock enable stretches a cycle and masks warm resets
   task automatic t_freeze();
      cpu_inst.run_op(16'h4044, 16'hC044, 1'b0);
      clock_enable = 1'b0;
      master_clear_reset = 1'b1;
      repeat (OPC + 20) @(negedge clock);
      check(memory_done_flag, 1'b0);
      master_clear_reset = 1'b0;
      clock_enable = 1'b1;
      wait_done();
      cpu_inst.reg_rd(CTRL_OFFSET, v);
      check(v[13], 1'b0);
   endtask : t_freeze
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (3) @(negedge clock);
      rst_n = 1'b1;
      t_reset();
      t_refused();
      t_word();
      t_block();
      t_flash();
      t_warm();
      t_freeze();
      end_sim();
   end
endmodule : tb
